// ### twm_pkg.sv
// Purpose: shared constants and types of the timer waveform mode and compare-output block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes: all offsets, field positions, reset values and fixed TOP values live here
package twm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_CTRL_A = 6'h00;
    localparam logic [5:0] OFS_CTRL_B = 6'h04;
    localparam logic [5:0] OFS_CMP_A = 6'h08;
    localparam logic [5:0] OFS_CMP_B = 6'h0C;
    localparam logic [5:0] OFS_CAPTURE = 6'h10;
    localparam logic [5:0] OFS_COUNTER = 6'h14;
    localparam logic [5:0] OFS_PIN_CTRL = 6'h18;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h1C;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
    localparam logic [5:0] OFS_PIN_STATE = 6'h24;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int COM_A_LSB = 6;
    localparam int COM_B_LSB = 4;
    localparam int WGM_LOW_LSB = 0;
    localparam int WGM_HIGH_LSB = 3;
    localparam int PIN_DIR_LSB = 0;
    localparam int PIN_DAT_LSB = 2;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_MATCH_A = 1;
    localparam int IRQ_MATCH_B = 2;
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and counter landmarks
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] ONE16 = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////////
    // mode decode
    localparam logic [2:0] FAST_VAR_TOP_HI = 3'h7;
    localparam logic [1:0] DUAL_VAR_TOP_HI = 2'h2;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [2:0] {
        K_NORMAL = 3'h0,
        K_CTC = 3'h1,
        K_FAST = 3'h3,
        K_PHASE = 3'h2,
        K_PFC = 3'h6
    } twm_kind_e;

    typedef enum logic [1:0] {
        SRC_FIXED = 2'h0,
        SRC_CMP_A = 2'h1,
        SRC_CAPTURE = 2'h3
    } twm_src_e;

    typedef enum logic [1:0] {
        AT_NOW = 2'h0,
        AT_TOP = 2'h1,
        AT_BOTTOM = 2'h3,
        AT_MAX = 2'h2
    } twm_point_e;

    typedef struct packed {
        logic [7:0] ctl_a;
        logic [1:0] wgm_hi;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] capture;
        logic [15:0] cnt;
        logic down;
        logic blk;
        logic oc_a;
        logic oc_b;
        logic [1:0] pin_dir;
        logic [1:0] pin_dat;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic irq;
        logic wait_req;
        logic [31:0] rdata;
        logic pa;
        logic pa_oe;
        logic pb;
        logic pb_oe;
    } twm_state_s;

    localparam twm_state_s ST_RST = '{wait_req: 1'b1, default: '0};

endpackage

// ### twm_mode_decode.sv
// Purpose: decode the 4-bit waveform mode into counting kind, TOP source and event points
// Assumes: purely combinational, driven from registered control bits
// Notes: the reserved code falls back to plain counting so the counter never locks up
`timescale 1ns/10ps
module twm_mode_decode (
    input wire logic [3:0] mode_in,
    output twm_pkg::twm_kind_e kind_out,
    output twm_pkg::twm_src_e src_out,
    output logic [15:0] fixed_top_out,
    output twm_pkg::twm_point_e upd_out,
    output twm_pkg::twm_point_e ovf_out
);

    always_comb begin
        fixed_top_out = twm_pkg::TOP_MAX;
        src_out = twm_pkg::SRC_FIXED;
        unique case (mode_in)
            4'h0, 4'hD: begin
                kind_out = twm_pkg::K_NORMAL;
                upd_out = twm_pkg::AT_NOW;
                ovf_out = twm_pkg::AT_MAX;
            end
            4'h1, 4'h2, 4'h3: begin
                kind_out = twm_pkg::K_PHASE;
                upd_out = twm_pkg::AT_TOP;
                ovf_out = twm_pkg::AT_BOTTOM;
                fixed_top_out = (mode_in == 4'h1) ? twm_pkg::TOP_8BIT :
                    (mode_in == 4'h2) ? twm_pkg::TOP_9BIT : twm_pkg::TOP_10BIT;
            end
            4'h4, 4'hC: begin
                kind_out = twm_pkg::K_CTC;
                upd_out = twm_pkg::AT_NOW;
                ovf_out = twm_pkg::AT_MAX;
                src_out = mode_in[3] ? twm_pkg::SRC_CAPTURE : twm_pkg::SRC_CMP_A;
            end
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: begin
                kind_out = twm_pkg::K_FAST;
                upd_out = twm_pkg::AT_TOP;
                ovf_out = twm_pkg::AT_TOP;
                fixed_top_out = (mode_in == 4'h5) ? twm_pkg::TOP_8BIT :
                    (mode_in == 4'h6) ? twm_pkg::TOP_9BIT : twm_pkg::TOP_10BIT;
                if (mode_in[3]) begin
                    src_out = mode_in[0] ? twm_pkg::SRC_CMP_A : twm_pkg::SRC_CAPTURE;
                end
            end
            4'h8, 4'h9: begin
                kind_out = twm_pkg::K_PFC;
                upd_out = twm_pkg::AT_BOTTOM;
                ovf_out = twm_pkg::AT_BOTTOM;
                src_out = mode_in[0] ? twm_pkg::SRC_CMP_A : twm_pkg::SRC_CAPTURE;
            end
            4'hA, 4'hB: begin
                kind_out = twm_pkg::K_PHASE;
                upd_out = twm_pkg::AT_TOP;
                ovf_out = twm_pkg::AT_BOTTOM;
                src_out = mode_in[0] ? twm_pkg::SRC_CMP_A : twm_pkg::SRC_CAPTURE;
            end
        endcase
    end

endmodule

// ### twm_waveform_ctrl.sv
// Purpose: 16-bit timer waveform mode and compare-output control with Avalon-MM registers
// Assumes: one clock; counter steps on every clock edge (no prescaler here)
// Notes: pins are split into value and enable; the pad logic outside resolves them
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module twm_waveform_ctrl (
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [5:0] ADDRESS_IN,
    input wire logic READ_IN,
    input wire logic WRITE_IN,
    input wire logic [31:0] WRITEDATA_IN,
    input wire logic [3:0] BYTEENABLE_IN,
    output logic [31:0] READDATA_OUT,
    output logic WAITREQUEST_OUT,
    output logic WAVE_A_OUT,
    output logic WAVE_A_OE_OUT,
    output logic WAVE_B_OUT,
    output logic WAVE_B_OE_OUT,
    output logic IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic wave_step(input twm_pkg::twm_kind_e kind, input logic [3:0] mode,
                                       input logic [1:0] com, input logic is_a,
                                       input logic match, input logic at_top,
                                       input logic down, input logic [15:0] cmp,
                                       input logic [15:0] top, input logic cur);
        logic r;
        r = cur;
        unique case (kind)
            twm_pkg::K_FAST: begin
                if (com == twm_pkg::COM_TOGGLE) begin
                    if (is_a && mode[3:1] == twm_pkg::FAST_VAR_TOP_HI && match) begin
                        r = ~cur;
                    end
                end else if (com[1]) begin
                    if (at_top) begin
                        r = ~com[0];
                    end else if (match && cmp != top) begin
                        r = com[0];
                    end
                end
            end
            twm_pkg::K_PHASE, twm_pkg::K_PFC: begin
                if (com == twm_pkg::COM_TOGGLE) begin
                    if (is_a && mode[3:2] == twm_pkg::DUAL_VAR_TOP_HI && match) begin
                        r = ~cur;
                    end
                end else if (com[1]) begin
                    if (cmp == twm_pkg::BOTTOM) begin
                        r = com[0];
                    end else if (cmp >= top) begin
                        r = ~com[0];
                    end else if (match) begin
                        r = down ^ com[0];
                    end
                end
            end
            twm_pkg::K_NORMAL, twm_pkg::K_CTC: begin
                if (match) begin
                    unique case (com)
                        twm_pkg::COM_OFF: r = cur;
                        twm_pkg::COM_TOGGLE: r = ~cur;
                        twm_pkg::COM_CLEAR: r = 1'b0;
                        twm_pkg::COM_SET: r = 1'b1;
                    endcase
                end
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // mode decode

    twm_pkg::twm_state_s st_reg;
    twm_pkg::twm_state_s st_next;
    logic [3:0] mode;
    twm_pkg::twm_kind_e kind;
    twm_pkg::twm_src_e src;
    twm_pkg::twm_point_e upd_at;
    twm_pkg::twm_point_e ovf_at;
    logic [15:0] fixed_top;

    assign mode = {st_reg.wgm_hi, st_reg.ctl_a[twm_pkg::WGM_LOW_LSB +: 2]};

    twm_mode_decode u_decode (
        .mode_in(mode),
        .kind_out(kind),
        .src_out(src),
        .fixed_top_out(fixed_top),
        .upd_out(upd_at),
        .ovf_out(ovf_at)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic [15:0] top;
    logic at_top;
    logic at_bot;
    logic dual;
    logic match_a;
    logic match_b;
    logic bus_done;
    logic cnt_wr;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [31:0] wv;

    always_comb begin
        st_next = st_reg;
        wv = 32'h0000_0000;
        top = fixed_top;
        unique case (src)
            twm_pkg::SRC_CMP_A: top = st_reg.cmp_a;
            twm_pkg::SRC_CAPTURE: top = st_reg.capture;
            twm_pkg::SRC_FIXED: top = fixed_top;
        endcase
        at_top = st_reg.cnt == top;
        at_bot = st_reg.cnt == twm_pkg::BOTTOM;
        dual = kind == twm_pkg::K_PHASE || kind == twm_pkg::K_PFC;
        // a counter write suppresses matches for one step, avoiding a spurious edge
        match_a = st_reg.cnt == st_reg.cmp_a && !st_reg.blk;
        match_b = st_reg.cnt == st_reg.cmp_b && !st_reg.blk;
        bus_done = (READ_IN || WRITE_IN) && !st_reg.wait_req;
        cnt_wr = WRITE_IN && bus_done && ADDRESS_IN == twm_pkg::OFS_COUNTER;

        // counting sequence
        if (dual) begin
            if (!st_reg.down) begin
                if (st_reg.cnt >= top) begin
                    st_next.down = 1'b1;
                    st_next.cnt = st_reg.cnt - twm_pkg::ONE16;
                end else begin
                    st_next.cnt = st_reg.cnt + twm_pkg::ONE16;
                end
            end else if (at_bot) begin
                st_next.down = 1'b0;
                st_next.cnt = st_reg.cnt + twm_pkg::ONE16;
            end else begin
                st_next.cnt = st_reg.cnt - twm_pkg::ONE16;
            end
        end else begin
            st_next.down = 1'b0;
            if ((kind == twm_pkg::K_CTC || kind == twm_pkg::K_FAST) && at_top) begin
                st_next.cnt = twm_pkg::BOTTOM;
            end else begin
                st_next.cnt = st_reg.cnt + twm_pkg::ONE16;
            end
        end

        // double-buffered compare update
        if (upd_at == twm_pkg::AT_NOW || (upd_at == twm_pkg::AT_TOP && at_top) ||
            (upd_at == twm_pkg::AT_BOTTOM && at_bot)) begin
            st_next.cmp_a = st_reg.buf_a;
            st_next.cmp_b = st_reg.buf_b;
        end

        // waveform outputs
        st_next.oc_a = wave_step(kind, mode, st_reg.ctl_a[twm_pkg::COM_A_LSB +: 2], 1'b1,
                                 match_a, at_top, st_reg.down, st_reg.cmp_a, top, st_reg.oc_a);
        st_next.oc_b = wave_step(kind, mode, st_reg.ctl_a[twm_pkg::COM_B_LSB +: 2], 1'b0,
                                 match_b, at_top, st_reg.down, st_reg.cmp_b, top, st_reg.oc_b);

        // events
        ev = 3'h0;
        unique case (ovf_at)
            twm_pkg::AT_MAX: ev[twm_pkg::IRQ_OVF] = st_reg.cnt == twm_pkg::TOP_MAX;
            twm_pkg::AT_TOP: ev[twm_pkg::IRQ_OVF] = at_top;
            twm_pkg::AT_BOTTOM: ev[twm_pkg::IRQ_OVF] = at_bot && st_reg.down;
            twm_pkg::AT_NOW: ev[twm_pkg::IRQ_OVF] = 1'b0;
        endcase
        ev[twm_pkg::IRQ_MATCH_A] = match_a;
        ev[twm_pkg::IRQ_MATCH_B] = match_b;

        // register writes, taken at the edge where waitrequest is seen low
        st_next.blk = cnt_wr;
        if (WRITE_IN && bus_done) begin
            unique case (ADDRESS_IN)
                twm_pkg::OFS_CTRL_A: begin
                    wv = merge_be({24'h0, st_reg.ctl_a}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.ctl_a = wv[7:0] & twm_pkg::CTRL_A_WMASK;
                end
                twm_pkg::OFS_CTRL_B: begin
                    wv = merge_be({27'h0, st_reg.wgm_hi, 3'h0}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.wgm_hi = wv[twm_pkg::WGM_HIGH_LSB +: 2];
                end
                twm_pkg::OFS_CMP_A: begin
                    wv = merge_be({16'h0, st_reg.buf_a}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.buf_a = wv[15:0];
                end
                twm_pkg::OFS_CMP_B: begin
                    wv = merge_be({16'h0, st_reg.buf_b}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.buf_b = wv[15:0];
                end
                twm_pkg::OFS_CAPTURE: begin
                    wv = merge_be({16'h0, st_reg.capture}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.capture = wv[15:0];
                end
                twm_pkg::OFS_COUNTER: begin
                    wv = merge_be({16'h0, st_reg.cnt}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.cnt = wv[15:0];
                end
                twm_pkg::OFS_PIN_CTRL: begin
                    wv = merge_be({28'h0, st_reg.pin_dat, st_reg.pin_dir}, WRITEDATA_IN,
                                  BYTEENABLE_IN);
                    st_next.pin_dir = wv[twm_pkg::PIN_DIR_LSB +: 2];
                    st_next.pin_dat = wv[twm_pkg::PIN_DAT_LSB +: 2];
                end
                twm_pkg::OFS_IRQ_MASK: begin
                    wv = merge_be({29'h0, st_reg.irq_mask}, WRITEDATA_IN, BYTEENABLE_IN);
                    st_next.irq_mask = wv[2:0];
                end
                default: st_next.blk = 1'b0;
            endcase
        end

        // read clears only the bits that were reported, so a new event is never lost
        clr = (READ_IN && bus_done && ADDRESS_IN == twm_pkg::OFS_IRQ_STATUS) ?
            st_reg.rdata[2:0] : 3'h0;
        st_next.irq_st = (st_reg.irq_st & ~clr) | ev;
        st_next.irq = |(st_next.irq_st & st_next.irq_mask);

        // one wait state, then the answer
        st_next.wait_req = !((READ_IN || WRITE_IN) && st_reg.wait_req);
        if (READ_IN && st_reg.wait_req) begin
            unique case (ADDRESS_IN)
                twm_pkg::OFS_CTRL_A: st_next.rdata = {24'h0, st_reg.ctl_a};
                twm_pkg::OFS_CTRL_B: st_next.rdata = {27'h0, st_reg.wgm_hi, 3'h0};
                twm_pkg::OFS_CMP_A: st_next.rdata = {16'h0, st_reg.buf_a};
                twm_pkg::OFS_CMP_B: st_next.rdata = {16'h0, st_reg.buf_b};
                twm_pkg::OFS_CAPTURE: st_next.rdata = {16'h0, st_reg.capture};
                twm_pkg::OFS_COUNTER: st_next.rdata = {16'h0, st_reg.cnt};
                twm_pkg::OFS_PIN_CTRL: st_next.rdata = {28'h0, st_reg.pin_dat, st_reg.pin_dir};
                twm_pkg::OFS_IRQ_STATUS: st_next.rdata = {29'h0, st_reg.irq_st};
                twm_pkg::OFS_IRQ_MASK: st_next.rdata = {29'h0, st_reg.irq_mask};
                twm_pkg::OFS_PIN_STATE: st_next.rdata = {29'h0, st_reg.down, st_reg.oc_b,
                                                         st_reg.oc_a};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end

        // pin override
        st_next.pa = |st_next.ctl_a[twm_pkg::COM_A_LSB +: 2] ? st_next.oc_a :
            st_next.pin_dat[0];
        st_next.pb = |st_next.ctl_a[twm_pkg::COM_B_LSB +: 2] ? st_next.oc_b :
            st_next.pin_dat[1];
        st_next.pa_oe = st_next.pin_dir[0];
        st_next.pb_oe = st_next.pin_dir[1];
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_reg <= twm_pkg::ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign READDATA_OUT = st_reg.rdata;
    assign WAITREQUEST_OUT = st_reg.wait_req;
    assign WAVE_A_OUT = st_reg.pa;
    assign WAVE_A_OE_OUT = st_reg.pa_oe;
    assign WAVE_B_OUT = st_reg.pb;
    assign WAVE_B_OE_OUT = st_reg.pb_oe;
    assign IRQ_OUT = st_reg.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    a_ctla_unused_zero: assert property (st_reg.ctl_a[3:2] == 2'h0)
        else $error("unused control A bits not zero");
    a_pin_a_owner: assert property (WAVE_A_OUT == (|st_reg.ctl_a[7:6] ? st_reg.oc_a :
        st_reg.pin_dat[0]) && WAVE_A_OE_OUT == st_reg.pin_dir[0])
        else $error("pin A owner wrong");
    a_normal_ovf: assert property (mode == 4'h0 && st_reg.cnt == 16'hFFFF && !cnt_wr
        |=> st_reg.cnt == 16'h0000 && st_reg.irq_st[0])
        else $error("mode 0 overflow at MAX missing");
    a_fast_wrap: assert property (kind == twm_pkg::K_FAST && at_top && !cnt_wr
        |=> st_reg.cnt == 16'h0000 && st_reg.irq_st[0])
        else $error("fast PWM did not wrap at TOP");
    a_dual_turn: assert property (dual && !st_reg.down && at_top && top != 16'h0000 && !cnt_wr
        |=> st_reg.down && st_reg.cnt == $past(st_reg.cnt) - 16'h0001)
        else $error("dual slope did not turn at TOP");
    a_ctc_toggle: assert property (kind == twm_pkg::K_CTC && st_reg.ctl_a[7:6] == 2'h1 &&
        match_a |=> st_reg.oc_a != $past(st_reg.oc_a))
        else $error("toggle on match missing");
    a_fast_top_set: assert property (kind == twm_pkg::K_FAST && st_reg.ctl_a[7:6] == 2'h2 &&
        at_top |=> st_reg.oc_a)
        else $error("fast PWM set at TOP missing");
    a_dual_bottom_low: assert property (dual && st_reg.ctl_a[7:6] == 2'h2 &&
        st_reg.cmp_a == 16'h0000 |=> !st_reg.oc_a)
        else $error("compare at BOTTOM not low");
    a_phase_update: assert property (kind == twm_pkg::K_PHASE && $changed(st_reg.cmp_a) &&
        $past(kind) == twm_pkg::K_PHASE |-> $past(at_top))
        else $error("phase correct compare updated off TOP");
    a_irq_level: assert property (IRQ_OUT == |(st_reg.irq_st & st_reg.irq_mask))
        else $error("interrupt level mismatch");

    c_fast_wrap: cover property (kind == twm_pkg::K_FAST && at_top ##1 at_bot);
    c_dual_turn: cover property (dual && at_top ##1 st_reg.down);
    c_irq_raise: cover property (!IRQ_OUT ##1 IRQ_OUT);
    c_normal_ovf: cover property (mode == 4'h0 && st_reg.cnt == 16'hFFFF);

endmodule

// ### twm_pin_model.sv
// Purpose: port pad seen by the waveform block, with its pull-up
// Assumes: one pad per channel, driver enable high while driving
// Notes: a released pad goes to the pull-up level, never to the last value
`timescale 1ns/10ps
module twm_pin_model (
    input wire logic val_in,
    input wire logic oe_in,
    output logic pad_out
);
    assign pad_out = oe_in ? val_in : 1'b1;
endmodule

// ### testbench.sv
// Purpose: self-checking bench for the timer waveform control block
// Assumes: bus answer time is waited for, never assumed
// Notes: pwm duty is judged by counting high cycles over whole periods, the steady 0 and 100 percent levels over 600 cycles
`timescale 1ns/10ps
module testbench;
logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wa, wao, wb, wbo, irq, wt, pad_a, pad_b;
logic [5:0] adr = 6'h00;
logic [31:0] wd = 32'h0, rdat, q;
logic [7:0] mode_tab [3] = '{8'h80, 8'hC0, 8'h40};
int bad_count = 0, num_checks = 0;
twm_waveform_ctrl i_dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .ADDRESS_IN(adr), .READ_IN(rd),
    .WRITE_IN(wr), .WRITEDATA_IN(wd), .BYTEENABLE_IN(4'hF), .READDATA_OUT(rdat),
    .WAITREQUEST_OUT(wt), .WAVE_A_OUT(wa), .WAVE_A_OE_OUT(wao), .WAVE_B_OUT(wb),
    .WAVE_B_OE_OUT(wbo), .IRQ_OUT(irq));
twm_pin_model i_pa (.val_in(wa), .oe_in(wao), .pad_out(pad_a));
twm_pin_model i_pb (.val_in(wb), .oe_in(wbo), .pad_out(pad_b));
initial forever #50 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
        bad_count++;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
endtask
// one extra edge after release so back-to-back calls never re-assign in one step
task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0) begin
        @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
endtask
task hi(input int n, input int e);
    logic [31:0] c;
    c = 32'h0;
    repeat (n) begin
        @(posedge clk);
        c = c + {31'h0, pad_a};
    end
    chk(c, e);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, twm_pkg::OFS_CTRL_A, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, twm_pkg::OFS_CTRL_A, 32'hFF);
    bus(1'b0, twm_pkg::OFS_CTRL_A, 32'h0);
    chk(q, 32'hF3);
    bus(1'b1, twm_pkg::OFS_CTRL_A, 32'h0);
    bus(1'b1, twm_pkg::OFS_PIN_CTRL, 32'h7);
    repeat (3) @(posedge clk);
    chk({pad_a, pad_b, wao, wbo}, 32'hB);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'h40);
    foreach (mode_tab[i]) begin
        bus(1'b1, twm_pkg::OFS_CTRL_A, {24'h0, mode_tab[i]});
        bus(1'b1, twm_pkg::OFS_COUNTER, 32'h0);
        repeat (100) @(posedge clk);
        chk(pad_a, {31'h0, i == 1});
    end
    chk(irq, 32'h0);
    bus(1'b1, twm_pkg::OFS_IRQ_MASK, 32'h2);
    @(posedge clk);
    chk(irq, 32'h1);
    bus(1'b0, twm_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(q, 32'h6);
    chk(irq, 32'h0);
    bus(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, twm_pkg::OFS_CTRL_B, 32'h08);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'h80);
    bus(1'b1, twm_pkg::OFS_CTRL_A, 32'h81);
    bus(1'b1, twm_pkg::OFS_COUNTER, 32'h0);
    repeat (300) @(posedge clk);
    hi(512, 258);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'hFF);
    repeat (300) @(posedge clk);
    hi(512, 512);
    bus(1'b1, twm_pkg::OFS_CTRL_B, 32'h0);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'h0);
    bus(1'b1, twm_pkg::OFS_COUNTER, 32'h0);
    repeat (600) @(posedge clk);
    hi(600, 0);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'hFF);
    repeat (600) @(posedge clk);
    hi(600, 600);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'h40);
    repeat (600) @(posedge clk);
    hi(1020, 256);
    bus(1'b1, twm_pkg::OFS_CTRL_A, 32'h41);
    bus(1'b1, twm_pkg::OFS_CTRL_B, 32'h10);
    bus(1'b1, twm_pkg::OFS_CMP_A, 32'h20);
    bus(1'b1, twm_pkg::OFS_COUNTER, 32'h0);
    repeat (300) @(posedge clk);
    hi(256, 128);
    bus(1'b1, twm_pkg::OFS_CTRL_B, 32'h18);
    bus(1'b1, twm_pkg::OFS_CTRL_A, 32'h43);
    bus(1'b1, twm_pkg::OFS_COUNTER, 32'h0);
    repeat (100) @(posedge clk);
    hi(132, 66);
    bus(1'b1, twm_pkg::OFS_CTRL_B, 32'h08);
    bus(1'b1, twm_pkg::OFS_CTRL_A, 32'h40);
    bus(1'b1, twm_pkg::OFS_COUNTER, 32'h0);
    repeat (100) @(posedge clk);
    hi(132, 66);
    bus(1'b1, twm_pkg::OFS_CTRL_B, 32'h0);
    bus(1'b0, twm_pkg::OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, twm_pkg::OFS_COUNTER, 32'hFFF0);
    bus(1'b0, twm_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(q & 32'h1, 32'h0);
    repeat (30) @(posedge clk);
    bus(1'b0, twm_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    end_of_test;
end
initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test;
end
endmodule
